// ==== verilog/cmcc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// configuration memory crc checker
module cmcc_top (
	input wire logic ref_clk,
	input wire logic arst_n,
	// configuration side, same clock
	input wire logic check_enable,
	input wire logic [cmcc_pkg::DIV_EXP_W-1:0] div_exp,
	input wire logic config_done,
	input wire logic cfg_word_valid,
	input wire logic [31:0] cfg_word,
	input wire logic cfg_frame_end,
	input wire logic [15:0] cfg_frame_crc,
	input wire logic cfg_ref_valid,
	input wire logic [31:0] cfg_ref_crc,
	// soft error model, same clock
	input wire logic upset_valid,
	input wire logic [cmcc_pkg::CELL_AW-1:0] upset_addr,
	input wire logic [4:0] upset_bit,
	// boundary scan pins, foreign domain
	input wire logic tck,
	input wire logic tdi,
	input wire logic shift_dr,
	input wire logic [cmcc_pkg::IR_W-1:0] instr,
	output logic tdo,
	// status
	output logic crc_error,
	output logic config_status_n,
	output logic user_mode,
	output logic [31:0] crc_result_signature
);
	import cmcc_pkg::*;

	// ==================================================
	// declarations
	logic [31:0] configuration_cell_memory [CELL_WORDS];
	logic [CELL_AW-1:0] cfg_addr;
	logic [CELL_AW-1:0] scan_addr;
	logic [15:0] frame_crc;
	logic [31:0] crc_reference_storage;
	logic [DIV_EXP_W-1:0] exp_held;
	logic tick;
	cmcc_phase_e phase;
	cmcc_phase_e next_phase;
	logic [12:0] pin_s1;
	logic [12:0] pin_s2;
	logic [12:0] pin_s3;
	logic [12:0] pin_q;
	logic [12:0] next_pin_q;
	logic tck_q;
	logic tck_rise;
	logic load_ref_active;
	logic [31:0] next_signature;

	cmcc_crc_if crc_bus ();

	// ==================================================
	// check clock enable
	cmcc_div u_div (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.run(user_mode),
		.exp_n(exp_held),
		.tick(tick)
	);

	// ==================================================
	// compute engine
	cmcc_crc32 u_crc (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.bus(crc_bus)
	);

	// ==================================================
	// phase sequencing
	// next phase from current phase and check tick
	always_comb begin
		next_phase = phase;
		unique case (phase)
			CMCC_CONFIG: begin
				if (config_done) begin
					next_phase = check_enable ? CMCC_SCAN : CMCC_HALT;
				end
			end
			CMCC_SCAN: begin
				if (tick && scan_addr == CELL_AW'(CELL_WORDS - 1)) begin
					next_phase = CMCC_FINISH;
				end
			end
			CMCC_FINISH: begin
				if (tick) begin
					next_phase = CMCC_SCAN;
				end
			end
			CMCC_HALT: begin
				next_phase = CMCC_HALT;
			end
		endcase
	end

	// phase register, only reset leaves the loop
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			phase <= CMCC_CONFIG;
		end else begin
			phase <= next_phase;
		end
	end

	// user mode flag from phase
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			user_mode <= 1'b0;
		end else begin
			user_mode <= (next_phase == CMCC_SCAN) ||
				(next_phase == CMCC_FINISH);
		end
	end

	// divisor exponent caught on user mode entry
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			exp_held <= '0;
		end else if (phase == CMCC_CONFIG && config_done) begin
			if (div_exp > DIV_EXP_MAX) begin
				exp_held <= DIV_EXP_MAX;
			end else begin
				exp_held <= div_exp;
			end
		end
	end

	// ==================================================
	// configuration load and frame checking
	// frame words fill the cell memory in order
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_addr <= '0;
		end else if (phase == CMCC_CONFIG && cfg_word_valid) begin
			cfg_addr <= cfg_addr + 6'h01;
		end
	end

	// memory writes, plus modelled cell upsets
	always_ff @(posedge ref_clk) begin
		if (phase == CMCC_CONFIG && cfg_word_valid) begin
			configuration_cell_memory[cfg_addr] <= cfg_word;
		end else if (upset_valid) begin
			configuration_cell_memory[upset_addr][upset_bit] <=
				~configuration_cell_memory[upset_addr][upset_bit];
		end
	end

	// frame crc16 runs while words shift in
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			frame_crc <= CRC16_INIT;
		end else if (phase != CMCC_CONFIG) begin
			frame_crc <= CRC16_INIT;
		end else if (cfg_frame_end) begin
			frame_crc <= CRC16_INIT;
		end else if (cfg_word_valid) begin
			frame_crc <= crc16_word(frame_crc, cfg_word);
		end
	end

	// mismatching frame pulls status low until reset
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			config_status_n <= 1'b1;
		end else if (phase == CMCC_CONFIG && cfg_frame_end &&
			cfg_frame_crc != frame_crc) begin
			config_status_n <= 1'b0;
		end
	end

	// ==================================================
	// boundary scan pin synchroniser
	// three stages, first read only by second
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
			pin_s3 <= '0;
		end else begin
			pin_s1 <= {tck, tdi, shift_dr, instr};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end

	// a bit changes once stages two and three agree
	always_comb begin
		for (int i = 0; i < 13; i++) begin
			next_pin_q[i] = (pin_s2[i] == pin_s3[i]) ? pin_s3[i] : pin_q[i];
		end
	end

	// filtered pin levels and tck history
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_q <= '0;
			tck_q <= 1'b0;
		end else begin
			pin_q <= next_pin_q;
			tck_q <= pin_q[12];
		end
	end

	assign tck_rise = pin_q[12] && !tck_q;
	// chain only live with the code loaded in user mode
	assign load_ref_active = user_mode && pin_q[10] &&
		pin_q[IR_W-1:0] == LOAD_REF_CODE;

	// ==================================================
	// reference storage register
	// loaded at config end, shifted by the tester
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			crc_reference_storage <= STORAGE_RST;
		end else if (phase == CMCC_CONFIG && cfg_ref_valid) begin
			crc_reference_storage <= cfg_ref_crc;
		end else if (load_ref_active && tck_rise) begin
			crc_reference_storage <= {pin_q[11],
				crc_reference_storage[31:1]};
		end
	end

	// serial out follows the chain's low bit
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			tdo <= 1'b0;
		end else begin
			tdo <= crc_reference_storage[0];
		end
	end

	// ==================================================
	// user mode scan of the whole memory
	// one word per check tick, wrapping forever
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			scan_addr <= '0;
		end else if (phase == CMCC_SCAN && tick) begin
			scan_addr <= scan_addr + 6'h01;
		end
	end

	// engine drive; scanning goes on during shifts
	assign crc_bus.en = (phase == CMCC_SCAN) && tick;
	assign crc_bus.data = configuration_cell_memory[scan_addr];
	assign crc_bus.clr = (phase == CMCC_FINISH) && tick;

	// ==================================================
	// signature and error flag
	// compare against stored reference, zero is clean
	assign next_signature = ~crc_bus.crc ^ crc_reference_storage;

	// signature holds the last whole pass only
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			crc_result_signature <= SIGNATURE_RST;
		end else if (phase == CMCC_FINISH && tick) begin
			crc_result_signature <= next_signature;
		end
	end

	// flag updates at pass end, no history kept
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			crc_error <= 1'b0;
		end else if (phase == CMCC_FINISH && tick) begin
			crc_error <= |next_signature;
		end
	end
endmodule
`default_nettype wire

// ==== verilog/cmcc_pkg.sv ====
`default_nettype none
package cmcc_pkg;
	// ==================================================
	// sizes
	localparam int CELL_WORDS = 64;
	localparam int CELL_AW = 6;
	localparam int DIV_EXP_W = 4;
	localparam int DIV_CNT_W = 8;
	localparam int IR_W = 10;
	// ==================================================
	// check clock rates
	localparam int CHECK_MAX_HZ = 80_000_000;
	localparam int CHECK_MIN_HZ = 312_500;
	localparam int REF_CLK_HZ = 20_000_000;
	localparam logic [3:0] DIV_EXP_MAX = 4'h8;
	// ==================================================
	// instruction and crc constants
	localparam logic [9:0] LOAD_REF_CODE = 10'h015;
	localparam logic [31:0] CRC32_POLY = 32'h04c11db7;
	localparam logic [31:0] CRC32_INIT = 32'hffffffff;
	localparam logic [15:0] CRC16_POLY = 16'h8005;
	localparam logic [15:0] CRC16_INIT = 16'hffff;
	// ==================================================
	// reset values
	localparam logic [31:0] SIGNATURE_RST = 32'h00000000;
	localparam logic [31:0] STORAGE_RST = 32'h00000000;
	// ==================================================
	// checker phases
	typedef enum logic [1:0] {
		CMCC_CONFIG = 2'b00,
		CMCC_SCAN = 2'b01,
		CMCC_FINISH = 2'b10,
		CMCC_HALT = 2'b11
	} cmcc_phase_e;

	// msb-first crc32 step over one word
	function automatic logic [31:0] crc32_word(input logic [31:0] c,
		input logic [31:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 31; i >= 0; i--) begin
			r = (r[31] ^ d[i]) ? ((r << 1) ^ CRC32_POLY) : (r << 1);
		end
		return r;
	endfunction

	// msb-first crc16 step over one word
	function automatic logic [15:0] crc16_word(input logic [15:0] c,
		input logic [31:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 31; i >= 0; i--) begin
			r = (r[15] ^ d[i]) ? ((r << 1) ^ CRC16_POLY) : (r << 1);
		end
		return r;
	endfunction
endpackage
`default_nettype wire

// ==== verilog/cmcc_crc_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// controller to crc32 engine
interface cmcc_crc_if;
	logic clr;
	logic en;
	logic [31:0] data;
	logic [31:0] crc;
	modport ctl (output clr, output en, output data, input crc);
	modport eng (input clr, input en, input data, output crc);
endinterface
`default_nettype wire

// ==== verilog/cmcc_crc32.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// running crc32 accumulator
module cmcc_crc32 (
	input wire logic ref_clk,
	input wire logic arst_n,
	cmcc_crc_if.eng bus
);
	import cmcc_pkg::*;

	// clear restarts, enable folds one word
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			bus.crc <= CRC32_INIT;
		end else if (bus.clr) begin
			bus.crc <= CRC32_INIT;
		end else if (bus.en) begin
			bus.crc <= crc32_word(bus.crc, bus.data);
		end
	end
endmodule
`default_nettype wire

// ==== verilog/cmcc_div.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// power-of-two tick divider
module cmcc_div (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic run,
	input wire logic [cmcc_pkg::DIV_EXP_W-1:0] exp_n,
	output logic tick
);
	import cmcc_pkg::*;

	logic [DIV_CNT_W-1:0] cnt;
	logic [DIV_CNT_W-1:0] mask;

	// terminal count is 2^n - 1
	assign mask = DIV_CNT_W'((9'h001 << exp_n) - 9'h001);

	// one pulse every 2^n cycles while running
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt <= '0;
			tick <= 1'b0;
		end else if (!run) begin
			cnt <= '0;
			tick <= 1'b0;
		end else if (cnt == mask) begin
			cnt <= '0;
			tick <= 1'b1;
		end else begin
			cnt <= cnt + 8'h01;
			tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ==== sim/cmcc_top_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// port checks for the crc checker
module cmcc_top_asserts (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic check_enable,
	input wire logic config_done,
	input wire logic cfg_frame_end,
	input wire logic crc_error,
	input wire logic config_status_n,
	input wire logic user_mode,
	input wire logic [31:0] crc_result_signature
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// flag and signature relations
	property p_flag; crc_error == (|crc_result_signature); endproperty
	property p_chg; $changed(crc_error) |-> $changed(crc_result_signature);
	endproperty
	property p_gap; $changed(crc_result_signature) |=>
		$stable(crc_result_signature) [*8]; endproperty
	// status and mode relations
	property p_stat; !config_status_n |=> !config_status_n; endproperty
	property p_fall; $fell(config_status_n) |-> $past(cfg_frame_end);
	endproperty
	property p_um; user_mode |=> user_mode; endproperty
	property p_start; $rose(config_done) && check_enable |=> user_mode;
	endproperty
	property p_idle; !user_mode |=> $stable(crc_result_signature); endproperty
	a_flag: assert property (p_flag) else $error("flag off");
	a_chg: assert property (p_chg) else $error("flag moved");
	a_gap: assert property (p_gap) else $error("short pass");
	a_stat: assert property (p_stat) else $error("status rose");
	a_fall: assert property (p_fall) else $error("status fell");
	a_um: assert property (p_um) else $error("check halted");
	a_start: assert property (p_start) else $error("no start");
	a_idle: assert property (p_idle) else $error("early sig");
	c_err: cover property ($rose(crc_error));
	c_stat: cover property ($fell(config_status_n));
	c_um: cover property ($rose(user_mode));
endmodule
bind cmcc_top cmcc_top_asserts u_chk (
	.ref_clk(ref_clk),
	.arst_n(arst_n),
	.check_enable(check_enable),
	.config_done(config_done),
	.cfg_frame_end(cfg_frame_end),
	.crc_error(crc_error),
	.config_status_n(config_status_n),
	.user_mode(user_mode),
	.crc_result_signature(crc_result_signature)
);
`default_nettype wire

// ==== sim/cmcc_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// system controller watching the error flag
module cmcc_monitor (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic crc_error,
	output logic [7:0] err_events
);
	logic last;
	// counts each new error report
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			last <= 1'b0;
			err_events <= 8'h00;
		end else begin
			last <= crc_error;
			if (crc_error && !last) begin
				err_events <= err_events + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// ==== sim/cmcc_top_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// bench for the crc checker
module cmcc_top_bench;
	import cmcc_pkg::*;
	localparam int P = 270; // two passes at n=1 plus margin
	logic ref_clk, arst_n, check_enable, config_done, cfg_word_valid;
	logic cfg_frame_end, cfg_ref_valid, upset_valid, tck, tdi, shift_dr;
	logic tdo, crc_error, config_status_n, user_mode;
	logic [3:0] div_exp;
	logic [31:0] cfg_word, cfg_ref_crc, sig, ref_v, got;
	logic [15:0] cfg_frame_crc;
	logic [5:0] upset_addr;
	logic [4:0] upset_bit;
	logic [9:0] instr;
	logic [7:0] ev;
	int miscompares = 0;
	int n_compared = 0;
	cmcc_top u_dut (.ref_clk(ref_clk), .arst_n(arst_n),
		.check_enable(check_enable), .div_exp(div_exp),
		.config_done(config_done), .cfg_word_valid(cfg_word_valid),
		.cfg_word(cfg_word), .cfg_frame_end(cfg_frame_end),
		.cfg_frame_crc(cfg_frame_crc), .cfg_ref_valid(cfg_ref_valid),
		.cfg_ref_crc(cfg_ref_crc), .upset_valid(upset_valid),
		.upset_addr(upset_addr), .upset_bit(upset_bit), .tck(tck),
		.tdi(tdi), .shift_dr(shift_dr), .instr(instr), .tdo(tdo),
		.crc_error(crc_error), .config_status_n(config_status_n),
		.user_mode(user_mode), .crc_result_signature(sig));
	cmcc_monitor u_mon (.ref_clk(ref_clk), .arst_n(arst_n),
		.crc_error(crc_error), .err_events(ev));
	// clock
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// expected crc32 over the cell words, optional flip
	function automatic logic [31:0] crc(input logic f);
		logic [31:0] r, d;
		r = 32'hffffffff;
		for (int i = 0; i < 64; i++) begin
			d = {26'h25a5a5a, i[5:0]};
			if (f && i == 5) d[7] = ~d[7];
			for (int b = 31; b >= 0; b--) begin
				r = (r[31] ^ d[b]) ? ((r << 1) ^ CRC32_POLY) : (r << 1);
			end
		end
		return r;
	endfunction
	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s exp %h got %h", s, e, g);
		end
	endtask
	task end_of_test;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task rst;
		arst_n <= 1'b0;
		config_done <= 1'b0;
		cyc(4);
		arst_n <= 1'b1;
		cyc(1);
	endtask
	// frame end with given crc16
	task fe(input logic [15:0] c);
		cfg_frame_end <= 1'b1;
		cfg_frame_crc <= c;
		cyc(1);
		cfg_frame_end <= 1'b0;
		cyc(2);
	endtask
	// flip cell 5 bit 7, then let two passes run
	task upset;
		upset_valid <= 1'b1;
		upset_addr <= 6'h05;
		upset_bit <= 5'h07;
		cyc(1);
		upset_valid <= 1'b0;
		cyc(P);
	endtask
	// scan 32 bits into storage, lsb first, old value out
	task shift(input logic [9:0] c, input logic [31:0] v,
		output logic [31:0] o);
		instr <= c;
		shift_dr <= 1'b1;
		for (int i = 0; i < 32; i++) begin
			tdi <= v[i];
			cyc(6);
			o[i] = tdo;
			tck <= 1'b1;
			cyc(6);
			tck <= 1'b0;
		end
		cyc(6);
		shift_dr <= 1'b0;
		cyc(P);
	endtask
	// watchdog
	initial begin
		cyc(20000);
		miscompares++;
		end_of_test;
	end
	// main sequence
	initial begin
		{cfg_word_valid, cfg_frame_end} <= 2'h0;
		{cfg_ref_valid, upset_valid, tck, tdi, shift_dr} <= 5'h00;
		{cfg_word, cfg_ref_crc, cfg_frame_crc} <= 80'h0;
		{upset_addr, upset_bit, instr} <= 21'h0;
		check_enable <= 1'b1;
		div_exp <= 4'h1;
		rst;
		fe(16'hffff);
		chk("status_n", 32'h1, 32'(config_status_n));
		fe(16'h0000);
		cyc(3);
		chk("status_n", 32'h0, 32'(config_status_n));
		rst;
		ref_v = ~crc(1'b0);
		for (int i = 0; i < 64; i++) begin
			cfg_word_valid <= 1'b1;
			cfg_word <= {26'h25a5a5a, i[5:0]};
			cyc(1);
		end
		cfg_word_valid <= 1'b0;
		cfg_ref_valid <= 1'b1;
		cfg_ref_crc <= ref_v;
		cyc(1);
		cfg_ref_valid <= 1'b0;
		config_done <= 1'b1;
		cyc(3);
		chk("user_mode", 32'h1, 32'(user_mode));
		cyc(P);
		chk("sig", 32'h0, sig);
		chk("err", 32'h0, 32'(crc_error));
		upset;
		chk("sig", ~crc(1'b1) ^ ref_v, sig);
		chk("err", 32'h1, 32'(crc_error));
		cyc(P);
		chk("err", 32'h1, 32'(crc_error));
		upset;
		chk("err", 32'h0, 32'(crc_error));
		shift(LOAD_REF_CODE, ref_v ^ 32'h1, got);
		chk("tdo", ref_v, got);
		chk("sig", 32'h1, sig);
		shift(10'h000, 32'h0, got);
		shift(LOAD_REF_CODE, ref_v, got);
		chk("tdo", ref_v ^ 32'h1, got);
		chk("sig", 32'h0, sig);
		chk("events", 32'h2, 32'(ev));
		// disabled checker never enters user mode
		check_enable <= 1'b0;
		rst;
		config_done <= 1'b1;
		cyc(5);
		chk("user_mode", 32'h0, 32'(user_mode));
		end_of_test;
	end
endmodule
`default_nettype wire
